//--- gst_defines.svh
// Constants for the gated sixteen-bit timer: selector codes and reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef GST_DEFINES_SVH
`define GST_DEFINES_SVH
`define GST_CS_INSTR 2'h0
`define GST_CS_SYSCLK 2'h1
`define GST_CS_EXT 2'h2
`define GST_CS_RSVD 2'h3
`define GST_GS_PIN 2'h0
`define GST_GS_TMR0 2'h1
`define GST_GS_CMP1 2'h2
`define GST_GS_CMP2 2'h3
`define GST_PRESC_LAST 2'h3
`define GST_COUNT_RST 16'h0000
`endif

//--- gst_pkg.sv
// Types shared by the gated timer modules.
// Assumes gst_defines.svh is reachable on the include path.
package gst_pkg;
  typedef enum logic [1:0] {
    GST_EDGE_WAIT_FALL = 2'b01,
    GST_EDGE_ARMED = 2'b10
  } gst_edge_t;
endpackage

//--- gst_sync_if.sv
// Interface carrying synchronised pin levels from the sampler to the timer core.
// Assumes one clock domain on both sides.
interface gst_sync_if;
  logic ext_clk;
  logic gate_pin;
  logic cmp1;
  logic cmp2;
  modport src (output ext_clk, output gate_pin, output cmp1, output cmp2);
  modport dst (input ext_clk, input gate_pin, input cmp1, input cmp2);
endinterface

//--- gst_pin_sync.sv
// Three-stage samplers for the asynchronous pins of the gated timer.
// Assumes pins are asynchronous to clk_sys_i; a level counts once stages two and three agree.
module gst_pin_sync (
  input wire logic clk_sys_i,   // System clock
  input wire logic reset_n_i,   // Async reset, active low
  input wire logic [3:0] pin_i, // Ext clock, gate pin, cmp1, cmp2
  gst_sync_if.src sync_o        // Filtered levels
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] lvl;
  } gst_sync_state_t;
  gst_sync_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 4; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o.ext_clk = st_q.lvl[0];
  assign sync_o.gate_pin = st_q.lvl[1];
  assign sync_o.cmp1 = st_q.lvl[2];
  assign sync_o.cmp2 = st_q.lvl[3];
endmodule

//--- gst_gate.sv
// Gate path: source select, polarity, toggle and single-pulse stages.
// Assumes all inputs are already in the clk_sys_i domain.
`include "gst_defines.svh"
module gst_gate
  import gst_pkg::*;
(
  input wire logic clk_sys_i,        // System clock
  input wire logic reset_n_i,        // Async reset, active low
  input wire logic [1:0] src_sel_i,  // Gate source select
  input wire logic pol_i,            // Gate polarity, 1 = high enables
  input wire logic toggle_en_i,      // Toggle mode
  input wire logic spm_en_i,         // Single-pulse mode
  input wire logic arm_set_i,        // Software sets arm bit
  input wire logic arm_clr_i,        // Software clears arm bit
  input wire logic pin_i,            // Gate pin level
  input wire logic tmr0_ovf_i,       // Timer0 overflow pulse
  input wire logic cmp1_i,           // Comparator one level
  input wire logic cmp2_i,           // Comparator two level
  output logic gate_o,               // Processed gate level
  output logic arm_o                 // Arm bit state
);
  typedef struct packed {
    logic src_prev;
    logic tog;
    logic arm;
    logic pulse;
  } gst_gate_state_t;
  gst_gate_state_t st_q, st_d;
  logic raw;
  logic pol_src;
  logic after_tog;
  logic rise;
  logic fall;

  always_comb begin
    unique case (src_sel_i)
      `GST_GS_PIN: raw = pin_i;
      `GST_GS_TMR0: raw = tmr0_ovf_i;
      `GST_GS_CMP1: raw = cmp1_i;
      `GST_GS_CMP2: raw = cmp2_i;
    endcase
  end

  assign pol_src = pol_i ? raw : ~raw;
  assign rise = pol_src & ~st_q.src_prev;
  assign after_tog = toggle_en_i ? st_q.tog : pol_src;

  always_comb begin
    logic tog_next;
    logic win_lvl;
    logic win_prev;
    tog_next = st_q.tog;
    win_lvl = 1'b0;
    win_prev = 1'b0;
    st_d = st_q;
    st_d.src_prev = pol_src;
    if (!toggle_en_i) begin
      tog_next = 1'b0;
    end else if (rise) begin
      tog_next = ~st_q.tog;
    end
    st_d.tog = tog_next;
    // With toggle on the window follows the toggled level, so it spans one full period
    win_lvl = toggle_en_i ? tog_next : pol_src;
    win_prev = toggle_en_i ? st_q.tog : st_q.src_prev;
    if (arm_clr_i) begin
      st_d.arm = 1'b0;
    end
    // A level already enabling when armed does not open the window: an edge is needed
    if (!spm_en_i) begin
      st_d.pulse = 1'b0;
    end else if (st_q.arm && !st_q.pulse && win_lvl && !win_prev) begin
      st_d.pulse = 1'b1;
    end else if (st_q.pulse && !win_lvl) begin
      st_d.pulse = 1'b0;
      st_d.arm = 1'b0;
    end
    // Software re-arm in the closing cycle wins over the self-clear
    if (arm_set_i) begin
      st_d.arm = 1'b1;
    end
  end

  assign fall = st_q.pulse & ~st_d.pulse;
  assign gate_o = spm_en_i ? st_q.pulse : after_tog;
  assign arm_o = st_q.arm;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  a_toggle_held_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !toggle_en_i |=> !st_q.tog) else $error("toggle flop not held clear");
  a_pulse_clears_arm: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (fall && spm_en_i && !arm_set_i) |=> !st_q.arm)
    else $error("arm not cleared at pulse end");
  a_toggle_flips: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (toggle_en_i && rise) |=> st_q.tog != $past(st_q.tog))
    else $error("toggle flop missed edge");
  a_pulse_needs_edge: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (spm_en_i && !toggle_en_i && !st_q.pulse && st_q.src_prev) |=> !st_q.pulse)
    else $error("single pulse opened without an edge");
  c_pulse_done: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) fall);
  c_toggle_run: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    toggle_en_i && rise);
endmodule

//--- gst_timer.sv
// Gated sixteen-bit timer top: count clock select, counting, gate status and flags.
// Assumes pins are asynchronous and control bits come from same-clock logic.
`include "gst_defines.svh"
module gst_timer
  import gst_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys_i,               // 50 MHz system clock
  input wire logic reset_n_i,               // Async reset, active low
  input wire logic timer_run_enable_i,      // Run enable
  input wire logic gate_enable_i,           // Gate enable
  input wire logic [1:0] count_clock_select_i, // Count clock select
  input wire logic low_freq_osc_enable_i,   // Oscillator enable
  input wire logic ext_sync_enable_i,       // Synchronise external count input
  input wire logic cmp_sync_enable_i,       // Synchronise comparator gates
  input wire logic external_count_input_i,  // External count pin
  input wire logic low_freq_osc_i,          // Dedicated oscillator output
  input wire logic gate_input_pin_i,        // Gate pin
  input wire logic tmr0_overflow_i,         // Timer0 overflow pulse
  input wire logic comparator_one_output_i, // Comparator one
  input wire logic comparator_two_output_i, // Comparator two
  input wire logic [1:0] gate_source_select_i, // Gate source select
  input wire logic gate_polarity_i,         // Gate polarity
  input wire logic gate_toggle_enable_i,    // Toggle mode
  input wire logic single_pulse_enable_i,   // Single-pulse mode
  input wire logic single_pulse_arm_set_i,  // Pulse: set arm bit
  input wire logic single_pulse_arm_clr_i,  // Pulse: clear arm bit
  input wire logic gate_event_irq_enable_i, // Gate event irq enable
  input wire logic count_low_wr_i,          // Pulse: write low byte
  input wire logic count_high_wr_i,         // Pulse: write high byte
  input wire logic [7:0] count_wdata_i,     // Write data byte
  input wire logic gate_event_flag_clr_i,   // Pulse: clear gate event flag
  input wire logic count_overflow_flag_clr_i, // Pulse: clear overflow flag
  output logic [7:0] count_low_byte_o,      // Count low byte
  output logic [7:0] count_high_byte_o,     // Count high byte
  output logic single_pulse_arm_o,          // Arm bit
  output logic gate_level_status_o,         // Gate level
  output logic gate_event_flag_o,           // Gate event flag
  output logic count_overflow_flag_o,       // Overflow flag
  output logic gate_irq_o                   // Gate event interrupt request
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [1:0] presc;
    logic ext_prev;
    gst_edge_t edge_st;
    logic gval;
    logic gflag;
    logic oflag;
    logic irq;
    logic arm;
  } gst_state_t;
  gst_state_t st_q, st_d;

  gst_sync_if sync_bus ();
  logic [3:0] pins;
  logic gate_proc;
  logic gate_arm;
  logic ext_lvl;
  logic cmp1_sel;
  logic cmp2_sel;
  logic tick;
  logic run;
  logic ext_mode;

  assign pins = {comparator_two_output_i, comparator_one_output_i,
                 gate_input_pin_i, external_count_input_i};

  gst_pin_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pin_i(pins),
    .sync_o(sync_bus)
  );

  // Unsynchronised comparator path trades metastability margin for zero latency
  assign cmp1_sel = cmp_sync_enable_i ? sync_bus.cmp1 : comparator_one_output_i;
  assign cmp2_sel = cmp_sync_enable_i ? sync_bus.cmp2 : comparator_two_output_i;

  gst_gate u_gate (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .src_sel_i(gate_source_select_i),
    .pol_i(gate_polarity_i),
    .toggle_en_i(gate_toggle_enable_i),
    .spm_en_i(single_pulse_enable_i),
    .arm_set_i(single_pulse_arm_set_i),
    .arm_clr_i(single_pulse_arm_clr_i),
    .pin_i(sync_bus.gate_pin),
    .tmr0_ovf_i(tmr0_overflow_i),
    .cmp1_i(cmp1_sel),
    .cmp2_i(cmp2_sel),
    .gate_o(gate_proc),
    .arm_o(gate_arm)
  );

  // The async choice still samples on clk_sys_i: all logic is single clock
  assign ext_lvl = count_clock_select_i == `GST_CS_EXT ?
                   (low_freq_osc_enable_i ? low_freq_osc_i :
                    (ext_sync_enable_i ? sync_bus.ext_clk : external_count_input_i)) :
                   1'b0;
  assign ext_mode = count_clock_select_i == `GST_CS_EXT;
  assign run = timer_run_enable_i && (!gate_enable_i || gate_proc);

  always_comb begin
    st_d = st_q;
    tick = 1'b0;
    st_d.ext_prev = ext_lvl;
    st_d.presc = st_q.presc + 2'h1;
    unique case (count_clock_select_i)
      `GST_CS_INSTR: tick = st_q.presc == `GST_PRESC_LAST;
      `GST_CS_SYSCLK: tick = 1'b1;
      `GST_CS_EXT: tick = ext_lvl && !st_q.ext_prev && st_q.edge_st == GST_EDGE_ARMED;
      default: tick = 1'b0;
    endcase
    // Counter-mode qualifier: wait for a falling edge after disable or write
    if (!timer_run_enable_i || count_low_wr_i || count_high_wr_i) begin
      st_d.edge_st = GST_EDGE_WAIT_FALL;
    end else if (ext_mode && !ext_lvl && st_q.ext_prev) begin
      st_d.edge_st = GST_EDGE_ARMED;
    end
    if (run && tick) begin
      st_d.count = st_q.count + 1'b1;
      if (&st_q.count) begin
        st_d.oflag = 1'b1;
      end
    end
    if (count_low_wr_i) begin
      st_d.count[7:0] = count_wdata_i;
    end
    if (count_high_wr_i) begin
      st_d.count[15:8] = count_wdata_i;
    end
    st_d.gval = gate_proc;
    if (gate_event_flag_clr_i) begin
      st_d.gflag = 1'b0;
    end
    if (st_q.gval && !gate_proc) begin
      st_d.gflag = 1'b1;
    end
    if (count_overflow_flag_clr_i && !(run && tick && &st_q.count)) begin
      st_d.oflag = 1'b0;
    end
    st_d.irq = st_d.gflag && gate_event_irq_enable_i;
    st_d.arm = gate_arm;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q.count <= `GST_COUNT_RST;
      st_q.presc <= 2'h0;
      st_q.ext_prev <= 1'b0;
      st_q.edge_st <= GST_EDGE_WAIT_FALL;
      st_q.gval <= 1'b0;
      st_q.gflag <= 1'b0;
      st_q.oflag <= 1'b0;
      st_q.irq <= 1'b0;
      st_q.arm <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_low_byte_o = st_q.count[7:0];
  assign count_high_byte_o = st_q.count[15:8];
  assign single_pulse_arm_o = st_q.arm;
  assign gate_level_status_o = st_q.gval;
  assign gate_event_flag_o = st_q.gflag;
  assign count_overflow_flag_o = st_q.oflag;
  assign gate_irq_o = st_q.irq;

  a_off_holds: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!timer_run_enable_i && !count_low_wr_i && !count_high_wr_i)
    |=> st_q.count == $past(st_q.count)) else $error("count moved while off");
  a_sysclk_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (timer_run_enable_i && !gate_enable_i && count_clock_select_i == `GST_CS_SYSCLK
     && !count_low_wr_i && !count_high_wr_i)
    |=> st_q.count == $past(st_q.count) + 16'h0001) else $error("sysclk step wrong");
  // Four steady prescaled cycles hold exactly one tick, whatever the prescaler phase
  a_instr_quarter: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (timer_run_enable_i && !gate_enable_i && count_clock_select_i == `GST_CS_INSTR
     && !count_low_wr_i && !count_high_wr_i) [*4]
    |=> st_q.count == $past(st_q.count, 4) + 16'h0001) else $error("instr rate wrong");
  a_reserved_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (count_clock_select_i == `GST_CS_RSVD && !count_low_wr_i && !count_high_wr_i)
    |=> st_q.count == $past(st_q.count)) else $error("reserved select counted");
  a_low_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    count_low_wr_i |=> st_q.count[7:0] == $past(count_wdata_i))
    else $error("low byte write lost");
  a_high_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    count_high_wr_i |=> st_q.count[15:8] == $past(count_wdata_i))
    else $error("high byte write lost");
  a_wait_fall: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    count_high_wr_i |=> st_q.edge_st == GST_EDGE_WAIT_FALL)
    else $error("edge qualifier not reset");
  a_off_rearm: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !timer_run_enable_i |=> st_q.edge_st == GST_EDGE_WAIT_FALL)
    else $error("edge qualifier kept while off");
  // Catches a stray count from a rise seen before the qualifying falling edge
  a_ext_needs_fall: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (ext_mode && st_q.edge_st != GST_EDGE_ARMED && !count_low_wr_i && !count_high_wr_i)
    |=> st_q.count == $past(st_q.count)) else $error("counted before a falling edge");
  a_gate_blocks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (gate_enable_i && !gate_proc && !count_low_wr_i && !count_high_wr_i)
    |=> st_q.count == $past(st_q.count)) else $error("counted with gate closed");
  a_gval_follows: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    1'b1 |=> st_q.gval == $past(gate_proc)) else $error("gate status stale");
  a_tmr0_gate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (gate_source_select_i == `GST_GS_TMR0 && gate_polarity_i && !gate_toggle_enable_i
     && !single_pulse_enable_i && tmr0_overflow_i) |=> st_q.gval)
    else $error("overflow pulse did not reach gate");
  a_cmp_raw: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (gate_source_select_i == `GST_GS_CMP1 && !cmp_sync_enable_i && gate_polarity_i
     && !gate_toggle_enable_i && !single_pulse_enable_i)
    |=> st_q.gval == $past(comparator_one_output_i))
    else $error("raw comparator gate lagged");
  a_gate_event: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st_q.gval && !gate_proc) |=> st_q.gflag) else $error("gate event flag missed");
  a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (gate_event_flag_clr_i && !st_q.gval) |=> !st_q.gflag)
    else $error("gate event flag not cleared");
  a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st_q.gflag && gate_event_irq_enable_i && !gate_event_flag_clr_i) |=> st_q.irq)
    else $error("gate irq missing");
  a_irq_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !gate_event_irq_enable_i |=> !st_q.irq) else $error("gate irq while disabled");
  a_ovf_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (run && tick && &st_q.count && !count_low_wr_i && !count_high_wr_i)
    |=> st_q.oflag && st_q.count == 16'h0000) else $error("overflow flag missed");
  a_ovf_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (count_overflow_flag_clr_i && !timer_run_enable_i) |=> !st_q.oflag)
    else $error("overflow flag not cleared");
  c_overflow: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(st_q.oflag));
  c_ext_count: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ext_mode && run && tick);
endmodule

//--- gst_far_model.sv
// Far-side model: count pin, oscillator, gate pin, comparators, Timer0 overflow.
// Assumes the bench calls its tasks; lines change only on falling clock edges.
module gst_far_model (
  input wire logic clk_sys_i, // System clock
  output logic ext_o,         // External count input
  output logic osc_o,         // Dedicated oscillator
  output logic gate_o,        // Gate pin
  output logic cmp1_o,        // Comparator one
  output logic cmp2_o,        // Comparator two
  output logic ovf_o          // Timer0 overflow pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ext_o, osc_o, gate_o, cmp1_o, cmp2_o, ovf_o} = 6'h00;
  end
  // Index follows the gate source codes; 4 and 5 are the count clocks
  task automatic set_lvl(input int idx, input logic v);
    @(negedge clk_sys_i);
    case (idx)
      0: gate_o = v;
      1: if (v) begin
        ovf_o = 1'b1;
        @(negedge clk_sys_i);
        ovf_o = 1'b0;
      end
      2: cmp1_o = v;
      3: cmp2_o = v;
      4: ext_o = v;
      default: osc_o = v;
    endcase
  endtask
  // Six cycles per level keeps every edge well clear of the pin sampler
  task automatic clk_pulses(input int idx, input int n);
    repeat (n) begin
      set_lvl(idx, 1'b0);
      repeat (5) @(negedge clk_sys_i);
      set_lvl(idx, 1'b1);
      repeat (5) @(negedge clk_sys_i);
    end
  endtask
endmodule

//--- gst_timer_tb_top.sv
// Self-checking bench for the gated sixteen-bit timer.
// Assumes gst_far_model plays the pins; inputs change on falling clock edges.
module gst_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0;
  logic timer_run_enable_i = 1'b0, gate_enable_i = 1'b0, low_freq_osc_enable_i = 1'b0;
  logic [1:0] count_clock_select_i = 2'h0, gate_source_select_i = 2'h0;
  logic ext_sync_enable_i = 1'b1, cmp_sync_enable_i = 1'b1, gate_polarity_i = 1'b1;
  logic gate_toggle_enable_i = 1'b0, single_pulse_enable_i = 1'b0;
  logic single_pulse_arm_set_i = 1'b0, single_pulse_arm_clr_i = 1'b0;
  logic gate_event_irq_enable_i = 1'b0, count_low_wr_i = 1'b0, count_high_wr_i = 1'b0;
  logic [7:0] count_wdata_i = 8'h00;
  logic gate_event_flag_clr_i = 1'b0, count_overflow_flag_clr_i = 1'b0;
  logic external_count_input_i, low_freq_osc_i, gate_input_pin_i, tmr0_overflow_i;
  logic comparator_one_output_i, comparator_two_output_i;
  logic [7:0] count_low_byte_o, count_high_byte_o;
  logic single_pulse_arm_o, gate_level_status_o, gate_event_flag_o;
  logic count_overflow_flag_o, gate_irq_o;
  logic [15:0] cnt, base, d, lfsr = 16'h78e5;
  int n, error_cnt = 0, checks = 0;
  assign cnt = {count_high_byte_o, count_low_byte_o};
  always #10 clk_sys_i = ~clk_sys_i;
  gst_timer dut_u (
    .clk_sys_i, .reset_n_i, .timer_run_enable_i, .gate_enable_i, .count_clock_select_i,
    .low_freq_osc_enable_i, .ext_sync_enable_i, .cmp_sync_enable_i,
    .external_count_input_i, .low_freq_osc_i, .gate_input_pin_i, .tmr0_overflow_i,
    .comparator_one_output_i, .comparator_two_output_i, .gate_source_select_i,
    .gate_polarity_i, .gate_toggle_enable_i, .single_pulse_enable_i,
    .single_pulse_arm_set_i, .single_pulse_arm_clr_i, .gate_event_irq_enable_i,
    .count_low_wr_i, .count_high_wr_i, .count_wdata_i, .gate_event_flag_clr_i,
    .count_overflow_flag_clr_i, .count_low_byte_o, .count_high_byte_o,
    .single_pulse_arm_o, .gate_level_status_o, .gate_event_flag_o,
    .count_overflow_flag_o, .gate_irq_o);
  gst_far_model far_u (
    .clk_sys_i(clk_sys_i), .ext_o(external_count_input_i), .osc_o(low_freq_osc_i),
    .gate_o(gate_input_pin_i), .cmp1_o(comparator_one_output_i),
    .cmp2_o(comparator_two_output_i), .ovf_o(tmr0_overflow_i));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_rate(input logic [1:0] cs, input int cycles);
    case (cs)
      2'h0: return 16'(cycles / 4);
      2'h1: return 16'(cycles);
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic hi, input logic [7:0] v);
    @(negedge clk_sys_i);
    count_wdata_i = v;
    if (hi) count_high_wr_i = 1'b1;
    else count_low_wr_i = 1'b1;
    @(negedge clk_sys_i);
    {count_high_wr_i, count_low_wr_i} = 2'b00;
  endtask
  task automatic clr_flags();
    @(negedge clk_sys_i);
    {gate_event_flag_clr_i, count_overflow_flag_clr_i} = 2'b11;
    @(negedge clk_sys_i);
    {gate_event_flag_clr_i, count_overflow_flag_clr_i} = 2'b00;
    cyc(2);
  endtask
  task automatic arm(input logic set);
    @(negedge clk_sys_i);
    if (set) single_pulse_arm_set_i = 1'b1;
    else single_pulse_arm_clr_i = 1'b1;
    @(negedge clk_sys_i);
    {single_pulse_arm_set_i, single_pulse_arm_clr_i} = 2'b00;
  endtask
  task automatic pin_pulse();
    far_u.set_lvl(0, 1'b1);
    cyc(10);
    far_u.set_lvl(0, 1'b0);
    cyc(10);
  endtask
  initial begin
    cyc(60000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    chk("reset", cnt, 16'h0000);
    chk("reset_flags", {11'h000, single_pulse_arm_o, gate_level_status_o, gate_event_flag_o,
        count_overflow_flag_o, gate_irq_o}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(i[0], lfsr[7:0]);
      chk("byte_wr", {8'h00, i[0] ? count_high_byte_o : count_low_byte_o}, {8'h00, lfsr[7:0]});
    end
    $display("test byte_write done");
    timer_run_enable_i = 1'b1;
    for (int cs = 0; cs < 4; cs++) begin
      count_clock_select_i = cs[1:0];
      cyc(2);
      base = cnt;
      cyc(40);
      chk("rate", cnt - base, exp_rate(cs[1:0], 40));
    end
    timer_run_enable_i = 1'b0;
    count_clock_select_i = 2'h1;
    cyc(2);
    base = cnt;
    cyc(20);
    chk("off", cnt - base, 16'h0);
    clr_flags();
    wr(1'b1, 8'hff);
    wr(1'b0, 8'hfe);
    chk("ovf_pre", 16'(count_overflow_flag_o), 16'h0);
    timer_run_enable_i = 1'b1;
    cyc(6);
    timer_run_enable_i = 1'b0;
    chk("ovf", 16'(count_overflow_flag_o), 16'h1);
    clr_flags();
    chk("ovf_clr", 16'(count_overflow_flag_o), 16'h0);
    $display("test clock_sources done");
    count_clock_select_i = 2'h2;
    timer_run_enable_i = 1'b1;
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      n = 2 + int'(lfsr[2:0]);
      ext_sync_enable_i = (k != 1);
      if (k == 2) begin
        far_u.set_lvl(4, 1'b0);
        cyc(8);
        wr(1'b0, lfsr[15:8]);
      end
      base = cnt;
      far_u.clk_pulses(4, n);
      cyc(8);
      chk("ext_cnt", cnt - base, 16'(k == 1 ? n : n - 1));
    end
    timer_run_enable_i = 1'b0;
    far_u.set_lvl(5, 1'b1);
    low_freq_osc_enable_i = 1'b1;
    timer_run_enable_i = 1'b1;
    base = cnt;
    far_u.clk_pulses(5, n);
    cyc(8);
    chk("osc_cnt", cnt - base, 16'(n));
    $display("test external done");
    timer_run_enable_i = 1'b0;
    for (int gs = 0; gs < 4; gs++) begin
      gate_source_select_i = gs[1:0];
      cmp_sync_enable_i = gs[0];
      gate_event_irq_enable_i = gs[1];
      clr_flags();
      far_u.set_lvl(gs, 1'b1);
      cyc(8);
      if (gs != 1) chk("gate_lvl", 16'(gate_level_status_o), 16'h1);
      far_u.set_lvl(gs, 1'b0);
      cyc(8);
      chk("gate_evt", {14'h0, gate_event_flag_o, gate_irq_o}, {14'h0, 1'b1, gs[1]});
    end
    $display("test gate_sources done");
    gate_source_select_i = 2'h0;
    count_clock_select_i = 2'h1;
    gate_enable_i = 1'b1;
    timer_run_enable_i = 1'b1;
    for (int p = 1; p >= 0; p--) begin
      gate_polarity_i = p[0];
      for (int lv = 0; lv < 2; lv++) begin
        far_u.set_lvl(0, p[0] ^ lv[0] ^ 1'b1);
        cyc(10);
        base = cnt;
        cyc(20);
        chk("gated", cnt - base, 16'(20 * lv));
      end
    end
    gate_polarity_i = 1'b1;
    cyc(12);
    gate_toggle_enable_i = 1'b1;
    pin_pulse();
    chk("tgl_hold", 16'(gate_level_status_o), 16'h1);
    gate_toggle_enable_i = 1'b0;
    cyc(4);
    chk("tgl_off", 16'(gate_level_status_o), 16'h0);
    gate_toggle_enable_i = 1'b1;
    pin_pulse();
    chk("tgl_clr", 16'(gate_level_status_o), 16'h1);
    pin_pulse();
    chk("tgl_2nd", 16'(gate_level_status_o), 16'h0);
    gate_toggle_enable_i = 1'b0;
    $display("test toggle done");
    single_pulse_enable_i = 1'b1;
    for (int t = 0; t < 2; t++) begin
      gate_toggle_enable_i = t[0];
      cyc(4);
      arm(1'b1);
      cyc(1);
      chk("arm", 16'(single_pulse_arm_o), 16'h1);
      base = cnt;
      pin_pulse();
      if (t == 1) begin
        chk("arm_half", 16'(single_pulse_arm_o), 16'h1);
        pin_pulse();
      end
      d = cnt - base;
      chk("sp_cnt", 16'(d >= 16'(10 + 10 * t - 2) && d <= 16'(12 + 10 * t)), 16'h1);
      chk("arm_done", 16'(single_pulse_arm_o), 16'h0);
      base = cnt;
      pin_pulse();
      chk("sp_ignore", cnt - base, 16'h0);
    end
    single_pulse_enable_i = 1'b0;
    arm(1'b0);
    $display("test single_pulse done");
    reset_n_i = 1'b0;
    cyc(2);
    reset_n_i = 1'b1;
    chk("mid_reset", cnt, 16'h0000);
    cyc(4);
    chk("reset_gated", cnt, 16'h0000);
    $display("test reset done");
    give_verdict();
  end
endmodule
